//--- logic/aopc_top.sv
// output port, output clock and sleep/nap control of the sampling converter
`timescale 1ns/1ps
`include "aopc_cfg.svh"
module aopc_top #(
   parameter int SLEEP_RECOVER_CYC = `AOPC_SLEEP_RECOVER_MS * 1000 * `AOPC_CLK_MHZ
) (
   input  wire logic                    core_clk_i,
   input  wire logic                    arst_n_i,
   input  wire logic                    encode_clock_in_i,
   input  wire logic                    shutdown_request_i,
   input  wire logic                    output_enable_n_i,
   input  wire logic [1:0]              output_mode_select_i,
   input  wire aopc_pkg::aopc_sample_t  sample_i,
   output wire logic [`AOPC_DATA_W-1:0] data_a_o,
   output wire logic                    overflow_flag_a_o,
   output wire logic [`AOPC_DATA_W-1:0] data_b_o,
   output wire logic                    overflow_flag_b_o,
   output wire logic                    overflow_flag_o,
   output wire logic                    sample_clock_out_a_o,
   output wire logic                    sample_clock_out_b_o,
   output wire logic                    sample_clock_out_o,
   output wire logic                    outputs_oe_o,
   output wire logic                    data_valid_o
);

   // -------------------------------------------------------------
   // constants and decode
   // -------------------------------------------------------------
   localparam int LAT = `AOPC_LATENCY;
   localparam int NAP_CYC_I = `AOPC_NAP_RECOVER_CYC;
   localparam logic [`AOPC_CNT_W-1:0] NAP_CNT = NAP_CYC_I[`AOPC_CNT_W-1:0];
   localparam logic [`AOPC_CNT_W-1:0] SLEEP_CNT = SLEEP_RECOVER_CYC[`AOPC_CNT_W-1:0];
   localparam logic [`AOPC_CNT_W-1:0] CNT_ONE = {{(`AOPC_CNT_W-1){1'b0}}, 1'b1};

   function automatic aopc_pkg::aopc_mode_t decode_mode(input logic [1:0] code);
      case (code)
         `AOPC_MODE_FULL: decode_mode = aopc_pkg::MODE_FULL;
         `AOPC_MODE_SIM:  decode_mode = aopc_pkg::MODE_SIM;
         `AOPC_MODE_INT:  decode_mode = aopc_pkg::MODE_INT;
         default:         decode_mode = aopc_pkg::MODE_LVDS;
      endcase
   endfunction

   aopc_pkg::aopc_state_t  st;
   aopc_pkg::aopc_state_t  next_st;
   logic [`AOPC_PIN_W-1:0] agree;
   logic [`AOPC_PIN_W-1:0] pin_next;
   logic                   enc_rise;
   logic                   shutdown_request;
   logic                   oe_n;
   logic                   active;
   aopc_pkg::aopc_mode_t   mode;
   aopc_pkg::aopc_sample_t out_smp;
   aopc_pkg::aopc_mode_t   mode_new;

   // -------------------------------------------------------------
   // pin sampling
   // -------------------------------------------------------------
   // a pin bit only moves once stages two and three agree
   assign agree    = ~(st.s2 ^ st.s3);
   assign pin_next = (agree & st.s3) | (~agree & st.pin);
   assign enc_rise = pin_next[`AOPC_PIN_ENC] & ~st.pin[`AOPC_PIN_ENC];
   assign shutdown_request     = st.pin[`AOPC_PIN_SHUTDOWN_REQUEST];
   assign oe_n     = st.pin[`AOPC_PIN_OEN];
   assign mode     = decode_mode(st.pin[`AOPC_PIN_MODE+1:`AOPC_PIN_MODE]);
   assign mode_new = decode_mode(pin_next[`AOPC_PIN_MODE+1:`AOPC_PIN_MODE]);
   assign active   = (st.pwr == aopc_pkg::PWR_RUN) || (st.pwr == aopc_pkg::PWR_RECOVER);
   assign out_smp  = st.pipe[LAT-1];

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      next_st     = st;
      next_st.s1  = {output_mode_select_i, output_enable_n_i, shutdown_request_i,
                     encode_clock_in_i};
      next_st.s2  = st.s1;
      next_st.s3  = st.s2;
      next_st.pin = pin_next;

      case (st.pwr)
         aopc_pkg::PWR_RUN: begin
            if (shutdown_request) begin
               // sleep or nap chosen by enable
               next_st.pwr = oe_n ? aopc_pkg::PWR_SLEEP : aopc_pkg::PWR_NAP;
            end
         end
         aopc_pkg::PWR_NAP: begin
            if (!shutdown_request) begin
               next_st.pwr  = aopc_pkg::PWR_RECOVER;
               next_st.slow = 1'b0;
               next_st.cnt  = NAP_CNT;
            end else if (oe_n) begin
               next_st.pwr = aopc_pkg::PWR_SLEEP;
            end
         end
         aopc_pkg::PWR_SLEEP: begin
            // reference was off, so leaving always takes the long wait
            if (!shutdown_request) begin
               // sleep exit waits for the reference
               next_st.pwr  = aopc_pkg::PWR_RECOVER;
               next_st.slow = 1'b1;
               next_st.cnt  = SLEEP_CNT;
            end
         end
         aopc_pkg::PWR_RECOVER: begin
            if (shutdown_request) begin
               next_st.pwr = oe_n ? aopc_pkg::PWR_SLEEP : aopc_pkg::PWR_NAP;
            end else if (st.slow || enc_rise) begin
               if (st.cnt <= {{(`AOPC_CNT_W-1){1'b0}}, 1'b1}) begin
                  next_st.pwr = aopc_pkg::PWR_RUN;
               end else begin
                  next_st.cnt = st.cnt - {{(`AOPC_CNT_W-1){1'b0}}, 1'b1};
               end
            end
         end
         default: begin
            next_st.pwr = aopc_pkg::PWR_RUN;
         end
      endcase

      // full-rate and lvds clocks follow the encode level
      if (active && (mode == aopc_pkg::MODE_FULL || mode == aopc_pkg::MODE_LVDS)) begin
         next_st.clk_a = pin_next[`AOPC_PIN_ENC];
      end

      if (active && enc_rise) begin
         // data and flag share one pipeline
         next_st.pipe  = {st.pipe[LAT-2:0], sample_i};
         next_st.phase = ~st.phase;
         case (mode)
            aopc_pkg::MODE_FULL, aopc_pkg::MODE_LVDS: begin
               // bus a updates as its clock rises
               next_st.bus_a.code = out_smp.code;
               next_st.bus_a.over = (mode == aopc_pkg::MODE_FULL) & out_smp.over;
               if (mode == aopc_pkg::MODE_LVDS) begin
                  next_st.flag_lvds = out_smp.over;
               end
            end
            aopc_pkg::MODE_INT: begin
               if (!st.phase) begin
                  next_st.bus_a = out_smp;
               end else begin
                  // bus b moves as its clock rises
                  next_st.bus_b = out_smp;
               end
               next_st.clk_a = ~st.phase;
               next_st.clk_b = st.phase;
            end
            default: begin
               // both buses together every second sample
               if (!st.phase) begin
                  next_st.held = out_smp;
               end else begin
                  next_st.bus_a = st.held;
                  // bus b moves as its clock falls
                  next_st.bus_b = out_smp;
               end
               next_st.clk_a = st.phase;
               next_st.clk_b = ~st.phase;
            end
         endcase
      end

      // demux clocks restart low
      // a demux mode entered with a clock still high would move a bus with no rising
      // clock, so phase and clocks restart low; a mode change landing on an encode
      // rise is not caught here, the mode pin is meant to stay fixed while converting
      if (mode_new != mode && !enc_rise &&
          (mode_new == aopc_pkg::MODE_SIM || mode_new == aopc_pkg::MODE_INT)) begin
         next_st.phase = 1'b0;
         next_st.clk_a = 1'b0;
         next_st.clk_b = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign data_a_o             = st.bus_a.code;
   assign overflow_flag_a_o    = st.bus_a.over;
   assign data_b_o             = st.bus_b.code;
   assign overflow_flag_b_o    = st.bus_b.over;
   assign overflow_flag_o      = st.flag_lvds;
   assign sample_clock_out_a_o = st.clk_a;
   assign sample_clock_out_b_o = st.clk_b;
   // lvds clock shares bus a timing
   assign sample_clock_out_o   = st.clk_a;
   // sleep and nap float every output
   assign outputs_oe_o         = active & ~oe_n;
   assign data_valid_o         = (st.pwr == aopc_pkg::PWR_RUN);

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);

   chk_full_bus_a: assert property (
      active && enc_rise && mode == aopc_pkg::MODE_FULL |=>
         data_a_o == $past(out_smp.code) && overflow_flag_a_o == $past(out_smp.over))
      else $error("bus a or its flag wrong in full mode");

   chk_lvds_flag: assert property (
      active && enc_rise && mode == aopc_pkg::MODE_LVDS |=>
         overflow_flag_o == $past(out_smp.over) && !overflow_flag_a_o)
      else $error("lvds flag does not follow sample");

   chk_clock_copy: assert property (
      $rose(sample_clock_out_a_o) && mode == aopc_pkg::MODE_FULL |-> $past(enc_rise))
      else $error("output clock rose without encode edge");

   chk_a_on_rise: assert property (
      $changed(data_a_o) && $stable(mode) && $past(active) |-> $rose(sample_clock_out_a_o))
      else $error("bus a changed away from clock rise");

   chk_b_interl: assert property (
      $changed(data_b_o) && mode == aopc_pkg::MODE_INT |-> $rose(sample_clock_out_b_o))
      else $error("interleaved bus b changed away from clock rise");

   chk_b_simul: assert property (
      $changed(data_b_o) && mode == aopc_pkg::MODE_SIM |-> $fell(sample_clock_out_b_o))
      else $error("simultaneous bus b changed away from clock fall");

   chk_lvds_edge: assert property (
      $changed(data_a_o) && mode == aopc_pkg::MODE_LVDS && $stable(mode) |->
         $rose(sample_clock_out_o))
      else $error("lvds data changed away from clock rise");

   chk_oe_float: assert property (
      st.s2[`AOPC_PIN_OEN] && st.s3[`AOPC_PIN_OEN] |=> !outputs_oe_o)
      else $error("outputs driven while enable is high");

   chk_run_hold: assert property (
      st.pwr == aopc_pkg::PWR_RUN && !shutdown_request |=> st.pwr == aopc_pkg::PWR_RUN)
      else $error("left conversion with shutdown low");

   chk_sleep_entry: assert property (
      st.pwr == aopc_pkg::PWR_RUN && shutdown_request && oe_n |=> st.pwr == aopc_pkg::PWR_SLEEP)
      else $error("sleep not entered");

   chk_sleep_exit: assert property (
      st.pwr == aopc_pkg::PWR_SLEEP && !shutdown_request |=>
         st.pwr == aopc_pkg::PWR_RECOVER && st.cnt == SLEEP_CNT && !data_valid_o)
      else $error("sleep exit does not start long recovery");

   chk_nap_exit: assert property (
      st.pwr == aopc_pkg::PWR_NAP && !shutdown_request |=>
         st.pwr == aopc_pkg::PWR_RECOVER && st.cnt == NAP_CNT && !st.slow)
      else $error("nap exit does not start encode count");

   chk_nap_entry: assert property (
      st.pwr == aopc_pkg::PWR_RUN && shutdown_request && !oe_n |=> st.pwr == aopc_pkg::PWR_NAP)
      else $error("nap not entered");

   chk_power_float: assert property (
      st.pwr == aopc_pkg::PWR_NAP || st.pwr == aopc_pkg::PWR_SLEEP |->
         !outputs_oe_o && !data_valid_o)
      else $error("outputs driven in sleep or nap");

   chk_demux_alt: assert property (
      active && enc_rise && mode == aopc_pkg::MODE_INT |=>
         sample_clock_out_b_o == $past(st.phase) && sample_clock_out_a_o != sample_clock_out_b_o)
      else $error("interleaved clocks not at half rate");

   chk_int_ready: assert property (
      mode == aopc_pkg::MODE_INT && !st.phase |-> !sample_clock_out_a_o)
      else $error("interleaved bus a clock high before its update");

   chk_sim_ready: assert property (
      mode == aopc_pkg::MODE_SIM && st.phase |-> !sample_clock_out_a_o && sample_clock_out_b_o)
      else $error("simultaneous clocks not set for the paired update");

   chk_recover_count: assert property (
      st.pwr == aopc_pkg::PWR_RECOVER && !st.slow && !shutdown_request && enc_rise && st.cnt > CNT_ONE |=>
         st.cnt == $past(st.cnt) - CNT_ONE)
      else $error("nap recovery does not count encode rises");

   chk_pipe_hold: assert property (
      !active |=> st.pipe == $past(st.pipe))
      else $error("sample taken while powered down");

   chk_sleep_stay: assert property (
      st.pwr == aopc_pkg::PWR_SLEEP && shutdown_request |=> st.pwr == aopc_pkg::PWR_SLEEP)
      else $error("sleep left while shutdown held");

   cov_int_start: cover property (mode == aopc_pkg::MODE_INT && !st.phase && enc_rise);
   cov_nap_done: cover property (
      st.pwr == aopc_pkg::PWR_RECOVER && !st.slow ##1 st.pwr == aopc_pkg::PWR_RUN);
   cov_sleep_done: cover property (
      st.pwr == aopc_pkg::PWR_RECOVER && st.slow ##1 st.pwr == aopc_pkg::PWR_RUN);
   cov_simul_b: cover property (mode == aopc_pkg::MODE_SIM && $changed(data_b_o));
   cov_lvds_flag: cover property (mode == aopc_pkg::MODE_LVDS && $rose(overflow_flag_o));

endmodule

//--- logic/aopc_cfg.svh
// constants for the converter output port and power state block
// How it works
// - cmos modes: bus a and bus b each carry their own out-of-range flag
// - lvds mode: one overflow flag travels with the data
// - output clock is a delayed copy of the encode clock rising edge
// - cmos bus a changes after its clock rises, receiver latches on fall
// - interleaved demux: bus b changes after its clock rises, latched on fall
// - simultaneous demux: bus b changes after its clock falls, latched on rise
// - lvds data changes after output clock rises, latched on its fall
// - output enable high puts data, flags and clocks into high impedance
// - shutdown low means normal conversion whatever the output enable level
// - shutdown high with output enable high powers everything down (sleep)
// - after sleep, output is marked invalid for milliseconds of reference recovery
// - shutdown high, enable low is nap; output valid 100 encode cycles after (from sleep the code stays in sleep until shutdown goes low)
// - in sleep and nap every digital output is high impedance
// - four-level mode input picks full cmos, simultaneous, interleaved or lvds
// - demux buses run at half rate, alternate or together
`ifndef AOPC_CFG_SVH
`define AOPC_CFG_SVH

`define AOPC_DATA_W          10
`define AOPC_LATENCY         5
`define AOPC_PIN_W           5
`define AOPC_PIN_ENC         0
`define AOPC_PIN_SHUTDOWN_REQUEST        1
`define AOPC_PIN_OEN         2
`define AOPC_PIN_MODE        3
`define AOPC_MODE_FULL       2'h0
`define AOPC_MODE_SIM        2'h1
`define AOPC_MODE_INT        2'h2
`define AOPC_MODE_LVDS       2'h3
`define AOPC_CLK_MHZ         250
`define AOPC_NAP_RECOVER_CYC 100
`define AOPC_SLEEP_RECOVER_MS 2
`define AOPC_CNT_W           20

`endif

//--- logic/aopc_pkg.sv
// types for the converter output port and power state block
`include "aopc_cfg.svh"
package aopc_pkg;

   typedef enum logic [1:0] {PWR_RUN, PWR_NAP, PWR_SLEEP, PWR_RECOVER} aopc_pwr_t;

   typedef enum logic [1:0] {MODE_FULL, MODE_SIM, MODE_INT, MODE_LVDS} aopc_mode_t;

   typedef struct packed {
      logic                     over;
      logic [`AOPC_DATA_W-1:0]  code;
   } aopc_sample_t;

   typedef struct packed {
      logic [`AOPC_PIN_W-1:0]   s1;
      logic [`AOPC_PIN_W-1:0]   s2;
      logic [`AOPC_PIN_W-1:0]   s3;
      logic [`AOPC_PIN_W-1:0]   pin;
      aopc_pwr_t                pwr;
      logic                     slow;
      logic [`AOPC_CNT_W-1:0]   cnt;
      logic                     phase;
      aopc_sample_t [`AOPC_LATENCY-1:0] pipe;
      aopc_sample_t             held;
      aopc_sample_t             bus_a;
      aopc_sample_t             bus_b;
      logic                     flag_lvds;
      logic                     clk_a;
      logic                     clk_b;
   } aopc_state_t;

endpackage

//--- testbench/aopc_rx_model.sv
// receiving logic model that latches the converter buses on their output clocks
`timescale 1ns/1ps
`include "aopc_cfg.svh"
module aopc_rx_model (
   input  wire logic                   core_clk_i,
   input  wire logic                   arst_n_i,
   input  wire logic [1:0]             mode_i,
   input  wire logic                   oe_i,
   input  wire aopc_pkg::aopc_sample_t bus_a_i,
   input  wire aopc_pkg::aopc_sample_t bus_b_i,
   input  wire logic                   clk_a_i,
   input  wire logic                   clk_b_i,
   output logic                        got_a_o,
   output logic                        got_b_o,
   output aopc_pkg::aopc_sample_t      cap_a_o,
   output aopc_pkg::aopc_sample_t      cap_b_o
);
   aopc_pkg::aopc_sample_t pin_a, pin_b, last_a, last_b;
   logic                   ck_a, ck_b, prev_a, prev_b, last_ca, last_cb, fall_a, edge_b;

   // released pins float: the model shows the inverse of the last driven level
   assign pin_a = oe_i ? bus_a_i : ~last_a;
   assign pin_b = oe_i ? bus_b_i : ~last_b;
   assign ck_a  = oe_i ? clk_a_i : ~last_ca;
   assign ck_b  = oe_i ? clk_b_i : ~last_cb;
   // bus a latched on clock fall
   assign fall_a = oe_i && prev_a && !ck_a;
   // bus b edge per update style
   assign edge_b = oe_i && ((mode_i == `AOPC_MODE_SIM) ? (!prev_b && ck_b) :
                   ((mode_i == `AOPC_MODE_INT) && prev_b && !ck_b));

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         {prev_a, prev_b, last_ca, last_cb, got_a_o, got_b_o} <= '0;
         {last_a, last_b, cap_a_o, cap_b_o} <= '0;
      end else begin
         prev_a  <= ck_a;
         prev_b  <= ck_b;
         got_a_o <= fall_a;
         got_b_o <= edge_b;
         if (oe_i) begin
            {last_a, last_b, last_ca, last_cb} <= {pin_a, pin_b, ck_a, ck_b};
         end
         if (fall_a) begin
            cap_a_o <= pin_a;
         end
         if (edge_b) begin
            cap_b_o <= pin_b;
         end
      end
   end
endmodule

//--- testbench/testbench.sv
// self-checking bench for the converter output port and power state block
`timescale 1ns/1ps
`include "aopc_cfg.svh"
module testbench;
   logic                    core_clk, arst_n, encode_clock_in, shutdown_request, oe_n;
   logic [1:0]              mode;
   aopc_pkg::aopc_sample_t  smp, cap_a, cap_b;
   aopc_pkg::aopc_sample_t  sent [0:1023];
   logic [`AOPC_DATA_W-1:0] data_a, data_b;
   logic                    flag_a, flag_b, flag_l, clk_a, clk_b, clk_o, oe, valid;
   logic                    got_a, got_b;
   int                      mismatches = 0;
   int                      checks = 0;
   int                      nrise = 0;
   int                      base = 100000;

   aopc_top #(.SLEEP_RECOVER_CYC(200)) i_dut (
      .core_clk_i(core_clk), .arst_n_i(arst_n), .encode_clock_in_i(encode_clock_in),
      .shutdown_request_i(shutdown_request), .output_enable_n_i(oe_n), .output_mode_select_i(mode),
      .sample_i(smp), .data_a_o(data_a), .overflow_flag_a_o(flag_a), .data_b_o(data_b),
      .overflow_flag_b_o(flag_b), .overflow_flag_o(flag_l), .sample_clock_out_a_o(clk_a),
      .sample_clock_out_b_o(clk_b), .sample_clock_out_o(clk_o), .outputs_oe_o(oe),
      .data_valid_o(valid));

   aopc_rx_model i_rx (
      .core_clk_i(core_clk), .arst_n_i(arst_n), .mode_i(mode), .oe_i(oe),
      .bus_a_i({(mode == `AOPC_MODE_LVDS) ? flag_l : flag_a, data_a}),
      .bus_b_i({flag_b, data_b}), .clk_a_i(clk_a), .clk_b_i(clk_b),
      .got_a_o(got_a), .got_b_o(got_b), .cap_a_o(cap_a), .cap_b_o(cap_b));

   // ----------------------------------------------------------------
   // clock, encode pin and helpers
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // 31 core cycles per encode period, close to 125 ns; a fresh sample each rise
   initial begin
      encode_clock_in = 1'b0;
      smp = '0;
      forever begin
         repeat (15) @(posedge core_clk);
         nrise = nrise + 1;
         sent[nrise % 1024] = {(nrise % 3) == 0, `AOPC_DATA_W'(nrise * 37 + 5)};
         smp <= sent[nrise % 1024];
         encode_clock_in <= 1'b1;
         repeat (16) @(posedge core_clk);
         encode_clock_in <= 1'b0;
      end
   end

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check_smp(input string name, input aopc_pkg::aopc_sample_t exp,
                            input aopc_pkg::aopc_sample_t got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check_bit(input string name, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic rises(input int n);
      repeat (n) @(posedge encode_clock_in);
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // lag in encode rises from taking a sample to the receiver latching bus a
   function automatic int lag_a();
      if (mode == `AOPC_MODE_INT) return 6;
      if (mode == `AOPC_MODE_SIM) return 7;
      return 5;
   endfunction

   // ----------------------------------------------------------------
   // stream checks on each latch of the partner while valid is high and the settling rises after base have passed
   // ----------------------------------------------------------------
   always @(posedge core_clk) begin
      if (got_a && valid && nrise > base + lag_a() + 3) begin
         check_smp("bus_a", sent[(nrise - lag_a()) % 1024], cap_a);
      end
      if (got_b && valid && nrise > base + 9) begin
         check_smp("bus_b", sent[(nrise - 6) % 1024], cap_b);
      end
   end

   initial begin
      cycles(100000);
      mismatches++;
      summarize;
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      shutdown_request   = 1'b0;
      oe_n   = 1'b0;
      mode   = `AOPC_MODE_FULL;
      cycles(8);
      arst_n <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         mode <= 2'(m);
         base = nrise;
         rises(20);
         // mode moves away from an encode rise so the demux clocks restart cleanly
         @(negedge encode_clock_in);
      end
      @(posedge encode_clock_in);
      cycles(8);
      check_bit("clk_out_rise", 1'b1, clk_o);
      @(negedge encode_clock_in);
      cycles(8);
      check_bit("clk_out_fall", 1'b0, clk_o);
      base = 100000;
      // output enable moves only while the stream checks are switched off
      oe_n <= 1'b1;
      cycles(8);
      check_bit("oe_off", 1'b0, oe);
      check_bit("valid_oe_off", 1'b1, valid);
      shutdown_request <= 1'b1;
      cycles(8);
      check_bit("valid_sleep", 1'b0, valid);
      check_bit("oe_sleep", 1'b0, oe);
      shutdown_request <= 1'b0;
      cycles(190);
      check_bit("valid_wake_early", 1'b0, valid);
      cycles(30);
      check_bit("valid_wake", 1'b1, valid);
      oe_n <= 1'b0;
      cycles(8);
      check_bit("oe_on", 1'b1, oe);
      shutdown_request <= 1'b1;
      cycles(8);
      check_bit("oe_nap", 1'b0, oe);
      check_bit("valid_nap", 1'b0, valid);
      @(negedge encode_clock_in);
      shutdown_request <= 1'b0;
      rises(99);
      cycles(8);
      check_bit("valid_nap_early", 1'b0, valid);
      check_bit("oe_recover", 1'b1, oe);
      rises(1);
      cycles(10);
      check_bit("valid_nap_done", 1'b1, valid);
      mode <= `AOPC_MODE_FULL;
      base = nrise;
      rises(12);
      summarize;
   end
endmodule
